// >>> usbfcs_defs.vh
// register offsets, field positions, reset values and timing counts of the usb control block
`ifndef USBFCS_DEFS_VH
`define USBFCS_DEFS_VH

`define USBFCS_ADDR_W 3
`define USBFCS_OFS_EVENT_STATUS 3'h0
`define USBFCS_OFS_EVENT_MASK 3'h1
`define USBFCS_OFS_CONTROL 3'h2
`define USBFCS_OFS_DEVICE_ADDRESS 3'h3
`define USBFCS_OFS_LAST_TOKEN 3'h4
`define USBFCS_OFS_ERROR_TYPE 3'h5
`define USBFCS_OFS_CONTROL_EP 3'h6

`define USBFCS_RST_EVENT_MASK 8'h00
`define USBFCS_RST_CONTROL 4'h6
`define USBFCS_RST_DEVICE_ADDRESS 7'h00

`define USBFCS_EV_SOF 0
`define USBFCS_EV_RESET 1
`define USBFCS_EV_END_OF_SUSPEND_FLAG 2
`define USBFCS_EV_SUSPEND_REQUEST_FLAG 3
`define USBFCS_EV_ERR 4
`define USBFCS_EV_SETUP_OVERRUN_FLAG 5
`define USBFCS_EV_CTR 7

`define USBFCS_CTL_RESET_FORCE 0
`define USBFCS_CTL_SUSPEND_FORCE 1
`define USBFCS_CTL_REGULATOR_OFF 2
`define USBFCS_CTL_RESUME 3
`define USBFCS_CTL_USBRST 6
`define USBFCS_CTL_RSM 7

`define USBFCS_STAT_DISABLED 2'h0
`define USBFCS_STAT_STALL 2'h1
`define USBFCS_STAT_NAK 2'h2
`define USBFCS_STAT_VALID 2'h3

`define USBFCS_PID_OUT 2'h0
`define USBFCS_PID_IN 2'h2
`define USBFCS_PID_SETUP 2'h3

`define USBFCS_EP0 3'h0
`define USBFCS_ERR_NONE 3'h0

`define USBFCS_IDLE_MS 3
`define USBFCS_CLK_KHZ 50000
`define USBFCS_IDLE_CNT_W 18

`endif

// >>> usbfcs_top.v
// control, status and event register logic of the full-speed usb function
`timescale 1ns/1ps
`default_nettype none
`include "usbfcs_defs.vh"

module usbfcs_top #(
	parameter IDLE_CYCLES = `USBFCS_IDLE_MS * `USBFCS_CLK_KHZ
) (
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire [`USBFCS_ADDR_W-1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire cpu_int_mask_i,
	input wire sie_sof_i,
	input wire sie_bus_reset_i,
	input wire sie_bus_idle_i,
	input wire sie_resume_start_i,
	input wire sie_err_i,
	input wire [2:0] sie_err_code_i,
	input wire sie_ctr_i,
	input wire [2:0] sie_ctr_ep_i,
	input wire sie_ctr_in_i,
	input wire [1:0] sie_ctr_pid_i,
	input wire sie_ep0_tx_ack_i,
	input wire sie_ep0_rx_ok_i,
	input wire sie_ep0_stall_i,
	input wire ep_other_ctr_i,
	output wire irq_o,
	output wire wake_irq_o,
	output wire usb_reset_o,
	output wire resume_drive_o,
	output wire regulator_off_o,
	output wire suspend_o,
	output wire [6:0] device_addr_o,
	output wire [1:0] ep0_tx_stat_o,
	output wire [1:0] ep0_rx_stat_o,
	output wire ep0_tx_toggle_o,
	output wire ep0_rx_toggle_o
);

	// counter width bounds the idle limit; the default fits in it
	localparam [`USBFCS_IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CYCLES[`USBFCS_IDLE_CNT_W-1:0];

	// event flags, bits 6 and 7 not stored here
	reg sof_q;
	reg reset_ev_q;
	reg end_of_suspend_flag_q;
	reg suspend_request_flag_q;
	reg err_q;
	reg setup_overrun_flag_q;
	reg [7:0] mask_q;
	reg [3:0] ctl_q;
	reg rsm_q;
	reg usbrst_q;
	reg [6:0] addr_q;
	reg [1:0] pid_q;
	reg dir_in_q;
	reg [2:0] ep_num_q;
	reg [2:0] err_code_q;
	reg ep0_ctr_q;
	reg tx_tog_q;
	reg [1:0] tx_stat_q;
	reg rx_tog_q;
	reg [1:0] rx_stat_q;
	reg [`USBFCS_IDLE_CNT_W-1:0] idle_cnt_q;
	reg [7:0] rdata_d;

	wire wr_event = reg_wr_i && (reg_addr_i == `USBFCS_OFS_EVENT_STATUS);
	wire wr_mask = reg_wr_i && (reg_addr_i == `USBFCS_OFS_EVENT_MASK);
	wire wr_ctl = reg_wr_i && (reg_addr_i == `USBFCS_OFS_CONTROL);
	wire wr_addr = reg_wr_i && (reg_addr_i == `USBFCS_OFS_DEVICE_ADDRESS);
	wire wr_ep0 = reg_wr_i && (reg_addr_i == `USBFCS_OFS_CONTROL_EP);

	wire reset_force = ctl_q[`USBFCS_CTL_RESET_FORCE];
	wire suspend_force = ctl_q[`USBFCS_CTL_SUSPEND_FORCE];
	// usb reset: received from the bus or forced by software
	wire usb_reset = sie_bus_reset_i | reset_force;
	// falling edge of force-reset by a software write
	wire reset_force_release = wr_ctl && reset_force && !reg_wdata_i[`USBFCS_CTL_RESET_FORCE];
	wire bus_active = !sie_bus_idle_i;
	wire wake = suspend_force && (bus_active || sie_resume_start_i || sie_bus_reset_i);

	wire ctr_ep0 = sie_ctr_i && (sie_ctr_ep_i == `USBFCS_EP0);
	wire ctr_epn = sie_ctr_i && (sie_ctr_ep_i != `USBFCS_EP0);
	wire setup_ep0 = ctr_ep0 && (sie_ctr_pid_i == `USBFCS_PID_SETUP);
	// setup while previous endpoint 0 event still pending
	wire setup_over = setup_ep0 && ep0_ctr_q;

	wire ctr_sum = ep0_ctr_q | ep_other_ctr_i;
	wire idle_hit = (idle_cnt_q == IDLE_LIMIT);
	wire [7:0] event_vec = {ctr_sum, 1'b0, setup_overrun_flag_q, err_q, suspend_request_flag_q, end_of_suspend_flag_q, reset_ev_q, sof_q};
	wire [7:0] live = event_vec & mask_q;

	// end-of-suspend has its own vector so it can wake a halted cpu
	assign wake_irq_o = live[`USBFCS_EV_END_OF_SUSPEND_FLAG] && !cpu_int_mask_i;
	assign irq_o = (|(live & 8'hfb)) && !cpu_int_mask_i;
	assign usb_reset_o = usb_reset;
	assign resume_drive_o = ctl_q[`USBFCS_CTL_RESUME];
	assign regulator_off_o = ctl_q[`USBFCS_CTL_REGULATOR_OFF];
	assign suspend_o = suspend_force;
	assign device_addr_o = addr_q;
	assign ep0_tx_stat_o = tx_stat_q;
	assign ep0_rx_stat_o = rx_stat_q;
	assign ep0_tx_toggle_o = tx_tog_q;
	assign ep0_rx_toggle_o = rx_tog_q;

	// event flags: hardware set wins over a software zero in the same cycle
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sof_q <= 1'b0;
			reset_ev_q <= 1'b0;
			end_of_suspend_flag_q <= 1'b0;
			suspend_request_flag_q <= 1'b0;
			err_q <= 1'b0;
			setup_overrun_flag_q <= 1'b0;
		end else begin
			sof_q <= sie_sof_i | (sof_q & ~(wr_event & ~reg_wdata_i[`USBFCS_EV_SOF]));
			reset_ev_q <= sie_bus_reset_i | reset_force_release
				| (reset_ev_q & ~(wr_event & ~reg_wdata_i[`USBFCS_EV_RESET]));
			end_of_suspend_flag_q <= wake
				| (end_of_suspend_flag_q & ~(wr_event & ~reg_wdata_i[`USBFCS_EV_END_OF_SUSPEND_FLAG]));
			suspend_request_flag_q <= (idle_hit & ~suspend_force)
				| (suspend_request_flag_q & ~(wr_event & ~reg_wdata_i[`USBFCS_EV_SUSPEND_REQUEST_FLAG]));
			err_q <= sie_err_i | (err_q & ~(wr_event & ~reg_wdata_i[`USBFCS_EV_ERR]));
			setup_overrun_flag_q <= setup_over
				| (setup_overrun_flag_q & ~(wr_event & ~reg_wdata_i[`USBFCS_EV_SETUP_OVERRUN_FLAG]));
		end
	end

	// error code follows the error flag, zeroed when software clears it
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			err_code_q <= `USBFCS_ERR_NONE;
		end else if (sie_err_i) begin
			err_code_q <= sie_err_code_i;
		end else if (wr_event && !reg_wdata_i[`USBFCS_EV_ERR]) begin
			err_code_q <= `USBFCS_ERR_NONE;
		end
	end

	// idle timer; saturates, so the suspend request is set again every cycle until the count is cleared
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			idle_cnt_q <= {`USBFCS_IDLE_CNT_W{1'b0}};
		end else if (usb_reset || suspend_force || bus_active) begin
			idle_cnt_q <= {`USBFCS_IDLE_CNT_W{1'b0}};
		end else if (!idle_hit) begin
			idle_cnt_q <= idle_cnt_q + 1'b1;
		end
	end

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mask_q <= `USBFCS_RST_EVENT_MASK;
		end else if (wr_mask) begin
			mask_q <= reg_wdata_i & 8'hbf;
		end
	end

	// control: force-suspend dropped by hardware when the bus wakes up
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl_q <= `USBFCS_RST_CONTROL;
		end else begin
			if (wr_ctl) begin
				ctl_q <= reg_wdata_i[3:0];
			end
			if (wake) begin
				ctl_q[`USBFCS_CTL_SUSPEND_FORCE] <= 1'b0;
			end
		end
	end

	// cause of wake-up; rearmed each time software forces suspend
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsm_q <= 1'b0;
			usbrst_q <= 1'b0;
		end else if (wr_ctl && reg_wdata_i[`USBFCS_CTL_SUSPEND_FORCE] && !suspend_force) begin
			rsm_q <= 1'b0;
			usbrst_q <= 1'b0;
		end else begin
			if (sie_resume_start_i) begin
				rsm_q <= 1'b1;
			end
			if (sie_bus_reset_i) begin
				usbrst_q <= 1'b1;
			end
		end
	end

	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_q <= `USBFCS_RST_DEVICE_ADDRESS;
		end else if (usb_reset) begin
			addr_q <= `USBFCS_RST_DEVICE_ADDRESS;
		end else if (wr_addr) begin
			addr_q <= reg_wdata_i[6:0];
		end
	end

	// last token status; a setup overrun leaves it untouched
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pid_q <= `USBFCS_PID_OUT;
			dir_in_q <= 1'b0;
			ep_num_q <= `USBFCS_EP0;
		end else if (ctr_ep0 && !setup_over) begin
			pid_q <= sie_ctr_pid_i;
			ep_num_q <= `USBFCS_EP0;
		end else if (ctr_epn) begin
			dir_in_q <= sie_ctr_in_i;
			ep_num_q <= sie_ctr_ep_i;
		end
	end

	// endpoint 0: hardware events win over a software write in the same cycle
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ep0_ctr_q <= 1'b0;
			tx_tog_q <= 1'b0;
			tx_stat_q <= `USBFCS_STAT_DISABLED;
			rx_tog_q <= 1'b0;
			rx_stat_q <= `USBFCS_STAT_DISABLED;
		end else begin
			if (ctr_ep0) begin
				ep0_ctr_q <= 1'b1;
			end else if (wr_ep0 && !reg_wdata_i[7]) begin
				ep0_ctr_q <= 1'b0;
			end
			if (usb_reset) begin
				tx_tog_q <= 1'b0;
				tx_stat_q <= `USBFCS_STAT_DISABLED;
				rx_tog_q <= 1'b0;
				rx_stat_q <= `USBFCS_STAT_DISABLED;
			end else if (sie_ep0_stall_i) begin
				tx_stat_q <= `USBFCS_STAT_STALL;
				rx_stat_q <= `USBFCS_STAT_STALL;
			end else if (setup_ep0) begin
				tx_tog_q <= 1'b1;
				rx_tog_q <= 1'b0;
				if (tx_stat_q != `USBFCS_STAT_DISABLED || rx_stat_q != `USBFCS_STAT_DISABLED) begin
					tx_stat_q <= `USBFCS_STAT_NAK;
					rx_stat_q <= `USBFCS_STAT_NAK;
				end
			end else begin
				if (wr_ep0) begin
					tx_tog_q <= reg_wdata_i[6];
					tx_stat_q <= reg_wdata_i[5:4];
					rx_tog_q <= reg_wdata_i[2];
					rx_stat_q <= reg_wdata_i[1:0];
				end
				if (sie_ep0_tx_ack_i) begin
					tx_tog_q <= ~tx_tog_q;
				end
				if (sie_ep0_rx_ok_i) begin
					rx_tog_q <= ~rx_tog_q;
				end
				if (ctr_ep0) begin
					tx_stat_q <= `USBFCS_STAT_NAK;
					rx_stat_q <= `USBFCS_STAT_NAK;
				end
			end
		end
	end

	// read mux; unmapped offsets read zero
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr_i)
			`USBFCS_OFS_EVENT_STATUS: rdata_d = event_vec;
			`USBFCS_OFS_EVENT_MASK: rdata_d = mask_q;
			`USBFCS_OFS_CONTROL: rdata_d = {rsm_q, usbrst_q, 2'b00, ctl_q};
			`USBFCS_OFS_DEVICE_ADDRESS: rdata_d = {1'b0, addr_q};
			`USBFCS_OFS_LAST_TOKEN: rdata_d = {pid_q, dir_in_q, 2'b00, ep_num_q};
			`USBFCS_OFS_ERROR_TYPE: rdata_d = {5'h00, err_code_q};
			`USBFCS_OFS_CONTROL_EP: rdata_d = {ep0_ctr_q, tx_tog_q, tx_stat_q, 1'b0,
				rx_tog_q, rx_stat_q};
			default: rdata_d = 8'h00;
		endcase
	end

	// data valid only in the cycle after the read strobe
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// >>> usbfcs_properties.sv
// port-level assertion checker for the usb control and status block
`timescale 1ns/1ps
`default_nettype none
`include "usbfcs_defs.vh"
module usbfcs_properties (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [`USBFCS_ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic cpu_int_mask_i,
	input wire logic sie_bus_reset_i,
	input wire logic sie_bus_idle_i,
	input wire logic sie_ctr_i,
	input wire logic [2:0] sie_ctr_ep_i,
	input wire logic [1:0] sie_ctr_pid_i,
	input wire logic sie_ep0_tx_ack_i,
	input wire logic sie_ep0_stall_i,
	input wire logic irq_o,
	input wire logic wake_irq_o,
	input wire logic usb_reset_o,
	input wire logic resume_drive_o,
	input wire logic regulator_off_o,
	input wire logic suspend_o,
	input wire logic [6:0] device_addr_o,
	input wire logic [1:0] ep0_tx_stat_o,
	input wire logic [1:0] ep0_rx_stat_o,
	input wire logic ep0_tx_toggle_o,
	input wire logic ep0_rx_toggle_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// reset and stall outrank every other endpoint 0 toggle and status update
	wire logic quiet = !usb_reset_o && !sie_ep0_stall_i;
	wire logic ep0_ctr = sie_ctr_i && sie_ctr_ep_i == `USBFCS_EP0;
	wire logic [1:0] ctl_bits = reg_wdata_i[3:2];
	AST_CPU_MASK: assert property (cpu_int_mask_i |-> !irq_o && !wake_irq_o)
		else $error("interrupt while cpu mask set");
	AST_BUS_RST: assert property (sie_bus_reset_i |-> usb_reset_o)
		else $error("bus reset not passed on");
	AST_RST_CLR: assert property (usb_reset_o |=> device_addr_o == 7'h00 && ep0_tx_stat_o == 2'h0
		&& ep0_rx_stat_o == 2'h0 && !ep0_tx_toggle_o && !ep0_rx_toggle_o)
		else $error("usb reset left state");
	AST_PWR_RST: assert property ($fell(sys_rst_i) |-> regulator_off_o && suspend_o && !resume_drive_o)
		else $error("control reset value wrong");
	AST_WAKE: assert property (suspend_o && !sie_bus_idle_i |=> !suspend_o)
		else $error("activity did not end suspend");
	AST_SETUP: assert property (ep0_ctr && sie_ctr_pid_i == `USBFCS_PID_SETUP && quiet
		|=> ep0_tx_toggle_o && !ep0_rx_toggle_o)
		else $error("setup toggles wrong");
	AST_STALL: assert property (sie_ep0_stall_i && !usb_reset_o |=> ep0_tx_stat_o == `USBFCS_STAT_STALL
		&& ep0_rx_stat_o == `USBFCS_STAT_STALL)
		else $error("stall not set on both");
	AST_CTR_NAK: assert property (ep0_ctr && sie_ctr_pid_i != `USBFCS_PID_SETUP && quiet
		|=> ep0_tx_stat_o == `USBFCS_STAT_NAK && ep0_rx_stat_o == `USBFCS_STAT_NAK)
		else $error("transfer did not nak both");
	AST_TX_ACK: assert property (sie_ep0_tx_ack_i && quiet && !sie_ctr_i && !reg_wr_i
		|=> ep0_tx_toggle_o != $past(ep0_tx_toggle_o))
		else $error("tx toggle did not flip");
	AST_CTL_WR: assert property (reg_wr_i && reg_addr_i == `USBFCS_OFS_CONTROL
		|=> {resume_drive_o, regulator_off_o} == $past(ctl_bits))
		else $error("control outputs not written");
	COV_SETUP: cover property (ep0_ctr && sie_ctr_pid_i == `USBFCS_PID_SETUP);
	COV_WAKE: cover property (suspend_o ##1 !suspend_o);
	COV_IRQ: cover property (irq_o);
endmodule
`default_nettype wire

// >>> usbfcs_sie_model.sv
// behavioural bus-side engine: one-cycle event pulses and the idle level
`timescale 1ns/1ps
`default_nettype none
module usbfcs_sie_model (
	input wire logic clk_i,
	output logic [7:0] ev_o,
	output logic [8:0] qual_o,
	output logic idle_o
);
	initial begin
		ev_o = 8'h00;
		qual_o = 9'h000;
		idle_o = 1'b1;
	end
	// qualifiers show the inverse once their strobe drops, never a stale copy
	task automatic pulse(input logic [7:0] ev, input logic [8:0] q);
		@(posedge clk_i);
		ev_o <= ev;
		qual_o <= q;
		@(posedge clk_i);
		ev_o <= 8'h00;
		qual_o <= ~q;
	endtask
	task automatic idle(input logic v);
		@(posedge clk_i);
		idle_o <= v;
	endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the usb control and status block
`timescale 1ns/1ps
`default_nettype none
`include "usbfcs_defs.vh"
module tb;
	logic sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, cpu_int_mask_i, ep_other_ctr_i;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	wire logic [7:0] reg_rdata_o, ev;
	wire logic [8:0] q;
	wire logic irq_o, wake_irq_o, usb_reset_o, resume_drive_o, regulator_off_o, suspend_o;
	wire logic ep0_tx_toggle_o, ep0_rx_toggle_o, sie_bus_idle_i;
	wire logic [6:0] device_addr_o;
	wire logic [1:0] ep0_tx_stat_o, ep0_rx_stat_o;
	int n_fail = 0;
	int checks_done = 0;
	logic [7:0] rst_val [0:7] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [2:0] errs [0:5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	usbfcs_sie_model sie (.clk_i(sys_clk_i), .ev_o(ev), .qual_o(q), .idle_o(sie_bus_idle_i));
	usbfcs_top #(.IDLE_CYCLES(20)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_int_mask_i(cpu_int_mask_i),
		.sie_sof_i(ev[0]), .sie_bus_reset_i(ev[1]), .sie_bus_idle_i(sie_bus_idle_i),
		.sie_resume_start_i(ev[2]), .sie_err_i(ev[3]), .sie_err_code_i(q[8:6]),
		.sie_ctr_i(ev[4]), .sie_ctr_ep_i(q[5:3]), .sie_ctr_in_i(q[0]), .sie_ctr_pid_i(q[2:1]),
		.sie_ep0_tx_ack_i(ev[5]), .sie_ep0_rx_ok_i(ev[6]), .sie_ep0_stall_i(ev[7]),
		.ep_other_ctr_i(ep_other_ctr_i), .irq_o(irq_o), .wake_irq_o(wake_irq_o),
		.usb_reset_o(usb_reset_o), .resume_drive_o(resume_drive_o),
		.regulator_off_o(regulator_off_o), .suspend_o(suspend_o), .device_addr_o(device_addr_o),
		.ep0_tx_stat_o(ep0_tx_stat_o), .ep0_rx_stat_o(ep0_rx_stat_o),
		.ep0_tx_toggle_o(ep0_tx_toggle_o), .ep0_rx_toggle_o(ep0_rx_toggle_o));
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	task automatic test_done;
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rdm(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o & m, e);
	endtask
	initial begin
		#200000;
		n_fail++;
		test_done;
	end
	initial begin
		{reg_wr_i, reg_rd_i, cpu_int_mask_i, ep_other_ctr_i} = 4'h0;
		reg_addr_i = 3'h0;
		reg_wdata_i = 8'h00;
		sys_rst_i = 1'b1;
		repeat (20) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 8; i++)
			rdm(i[2:0], 8'hff, rst_val[i]);
		wr(3'h2, 8'h00);
		sie.idle(1'b0);
		chk(regulator_off_o, 8'h00);
		// supply settling time before any bus traffic
		repeat (150) @(posedge sys_clk_i);
		wr(3'h1, 8'hff);
		rdm(3'h1, 8'hff, 8'hbf);
		sie.pulse(8'h01, 9'h000);
		rdm(3'h0, 8'h01, 8'h01);
		chk(irq_o, 8'h01);
		@(posedge sys_clk_i);
		cpu_int_mask_i <= 1'b1;
		@(posedge sys_clk_i);
		chk(irq_o, 8'h00);
		cpu_int_mask_i <= 1'b0;
		wr(3'h0, 8'hfe);
		rdm(3'h0, 8'h01, 8'h00);
		sie.pulse(8'h02, 9'h000);
		rdm(3'h0, 8'h02, 8'h02);
		rdm(3'h2, 8'h40, 8'h40);
		wr(3'h0, 8'hff);
		rdm(3'h0, 8'h02, 8'h02);
		foreach (errs[j]) begin
			sie.pulse(8'h08, {errs[j], 6'h00});
			rdm(3'h5, 8'hff, {5'h00, errs[j]});
			wr(3'h0, 8'hef);
			rdm(3'h5, 8'hff, 8'h00);
		end
		wr(3'h3, 8'hff);
		rdm(3'h3, 8'hff, 8'h7f);
		chk({1'b0, device_addr_o}, 8'h7f);
		wr(3'h2, 8'h01);
		chk(usb_reset_o, 8'h01);
		rdm(3'h3, 8'hff, 8'h00);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h00);
		rdm(3'h0, 8'h02, 8'h02);
		sie.idle(1'b1);
		wr(3'h2, 8'h02);
		repeat (30) @(posedge sys_clk_i);
		rdm(3'h0, 8'h08, 8'h00);
		chk(suspend_o, 8'h01);
		sie.pulse(8'h04, 9'h000);
		rdm(3'h0, 8'h04, 8'h04);
		chk(wake_irq_o, 8'h01);
		rdm(3'h2, 8'h82, 8'h80);
		repeat (25) @(posedge sys_clk_i);
		rdm(3'h0, 8'h08, 8'h08);
		sie.idle(1'b0);
		wr(3'h2, 8'h0c);
		chk({resume_drive_o, regulator_off_o}, 8'h03);
		wr(3'h2, 8'h00);
		chk({resume_drive_o, regulator_off_o}, 8'h00);
		wr(3'h6, 8'h33);
		rdm(3'h6, 8'hff, 8'h33);
		sie.pulse(8'h10, 9'h006);
		rdm(3'h6, 8'hff, 8'he2);
		chk({6'h00, ep0_tx_toggle_o, ep0_rx_toggle_o}, 8'h02);
		rdm(3'h4, 8'hff, 8'hc0);
		sie.pulse(8'h20, 9'h000);
		rdm(3'h6, 8'hff, 8'ha2);
		sie.pulse(8'h40, 9'h000);
		rdm(3'h6, 8'hff, 8'ha6);
		wr(3'h6, 8'h33);
		sie.pulse(8'h10, 9'h000);
		rdm(3'h6, 8'hff, 8'ha2);
		rdm(3'h4, 8'hff, 8'h00);
		sie.pulse(8'h80, 9'h000);
		rdm(3'h6, 8'hff, 8'h91);
		chk({4'h0, ep0_tx_stat_o, ep0_rx_stat_o}, 8'h05);
		sie.pulse(8'h10, 9'h029);
		rdm(3'h4, 8'hff, 8'h25);
		sie.pulse(8'h02, 9'h000);
		rdm(3'h6, 8'hff, 8'h80);
		wr(3'h6, 8'h00);
		@(posedge sys_clk_i);
		ep_other_ctr_i <= 1'b1;
		rdm(3'h0, 8'h80, 8'h80);
		@(posedge sys_clk_i);
		ep_other_ctr_i <= 1'b0;
		rdm(3'h0, 8'h80, 8'h00);
		test_done;
	end
endmodule
bind usbfcs_top usbfcs_properties u_props (.*);
`default_nettype wire
